// ### rtl/afc_top.sv
`timescale 1ns/100ps
`include "afc_regs.svh"
module afc_top #(
	parameter int DW = 16,
	parameter int AW = 12
) (
	input wire logic REF_CLK,
	input wire logic RST,
	input wire logic PSEL,
	input wire logic PENABLE,
	input wire logic PWRITE,
	input wire logic [15:0] PADDR,
	input wire logic [31:0] PWDATA,
	output logic [31:0] PRDATA,
	output logic PREADY,
	output logic PSLVERR,
	output logic IRQ
);
	localparam int ACCW = DW + AW + 2;
	localparam int DEPTH = 1 << AW;

	// ************************************************************
	// Declarations
	// ************************************************************
	logic signed [DW-1:0] tap_mem [DEPTH];
	logic signed [DW-1:0] coef_mem [DEPTH];
	logic [11:0] ctrl_r, ctrl_nxt;
	logic [AW-1:0] cnt_r, cnt_nxt, tb_r, tb_nxt, cb_r, cb_nxt;
	logic signed [DW-1:0] step_r, step_nxt, pend_data_r, pend_data_nxt;
	logic pend_r, pend_nxt, full_r, full_nxt;
	logic [1:0] irq_st_r, irq_st_nxt, irq_mask_r, irq_mask_nxt;
	logic pready_r, pready_nxt, pslverr_r, pslverr_nxt, irq_r, irq_nxt;
	logic [31:0] prdata_r, prdata_nxt, rd_data;
	logic rd_err;
	afc_pkg::afc_state_t state_r, state_nxt;
	logic [AW-1:0] idx_r, idx_nxt, ptr_r, ptr_nxt, prime_r, prime_nxt;
	logic [AW-1:0] ptr_inc, tap_off, tap_ra, coef_ra, mem_idx;
	logic signed [ACCW-1:0] acc_r, acc_nxt, sum;
	logic signed [DW-1:0] result_r, result_nxt, tap_rd, coef_rd, mac_a, upd_val;
	logic signed [DW:0] mac_p;
	logic acc_ph, wr_ok, rd_ok, reg_win, step_wr, sample_wr, en, adaptive_mode, busy;
	logic take, ev_full, ev_upd, apb_tap_we, apb_coef_we;
	logic tap_we, coef_we;
	logic [AW-1:0] tap_wa, coef_wa;
	logic signed [DW-1:0] tap_wd, coef_wd;
	logic [11:0] csr_rd;

	function automatic logic signed [DW-1:0] sat(input logic signed [ACCW-1:0] v);
		if (v[ACCW-1:DW-1] == '0 || v[ACCW-1:DW-1] == '1)
			return v[DW-1:0];
		else if (v[ACCW-1])
			return {1'b1, {(DW-1){1'b0}}};
		else
			return {1'b0, {(DW-1){1'b1}}};
	endfunction

	// ************************************************************
	// APB decode
	// ************************************************************
	assign acc_ph = PSEL & PENABLE;
	assign wr_ok = acc_ph & pready_r & PWRITE & ~rd_err;
	assign rd_ok = acc_ph & pready_r & ~PWRITE & ~rd_err;
	assign reg_win = PADDR[15:14] == `AFC_WIN_REGS;
	assign step_wr = wr_ok & (PADDR == `AFC_OFF_STEP);
	assign sample_wr = wr_ok & (PADDR == `AFC_OFF_SAMPLE);
	assign mem_idx = PADDR[AW+1:2];
	assign en = ctrl_r[`AFC_CSR_EN];
	assign adaptive_mode = ctrl_r[`AFC_CSR_ADP];
	assign busy = (state_r == afc_pkg::ST_WAITK) || (state_r == afc_pkg::ST_UPD);
	assign apb_tap_we = wr_ok & (PADDR[15:14] == `AFC_WIN_TAP);
	assign apb_coef_we = wr_ok & (PADDR[15:14] == `AFC_WIN_COEF);

	always_comb
	begin
		csr_rd = ctrl_r & `AFC_CSR_WMASK;
		csr_rd[`AFC_CSR_BUSY] = busy;
		csr_rd[`AFC_CSR_FULL] = full_r;
		rd_data = 32'h0000_0000;
		rd_err = 1'b0;
		case (PADDR[15:14])
			`AFC_WIN_REGS:
			begin
				case (PADDR)
					`AFC_OFF_CSR: rd_data = {20'h0_0000, csr_rd};
					`AFC_OFF_CNT: rd_data = 32'(cnt_r);
					`AFC_OFF_TAPB: rd_data = 32'(tb_r);
					`AFC_OFF_COEFB: rd_data = 32'(cb_r);
					`AFC_OFF_SAMPLE: rd_data = 32'h0000_0000;
					`AFC_OFF_RESULT: rd_data = 32'(result_r);
					`AFC_OFF_STEP: rd_data = 32'h0000_0000;
					`AFC_OFF_IRQ_ST: rd_data = {30'h0, irq_st_r};
					`AFC_OFF_IRQ_MASK: rd_data = {30'h0, irq_mask_r};
					default: rd_err = 1'b1;
				endcase
			end
			// Shared buffers are only reachable while the engine is idle
			`AFC_WIN_TAP:
			begin
				rd_data = 32'(tap_mem[mem_idx]);
				rd_err = state_r != afc_pkg::ST_IDLE;
			end
			`AFC_WIN_COEF:
			begin
				rd_data = 32'(coef_mem[mem_idx]);
				rd_err = state_r != afc_pkg::ST_IDLE;
			end
			default: rd_err = 1'b1;
		endcase
	end

	// ************************************************************
	// Register file and bus answer
	// ************************************************************
	always_comb
	begin
		ctrl_nxt = ctrl_r;
		cnt_nxt = cnt_r;
		tb_nxt = tb_r;
		cb_nxt = cb_r;
		step_nxt = step_r;
		pend_nxt = pend_r;
		pend_data_nxt = pend_data_r;
		irq_mask_nxt = irq_mask_r;
		irq_st_nxt = irq_st_r;
		full_nxt = full_r;
		if (take)
			pend_nxt = 1'b0;
		if (wr_ok && reg_win)
		begin
			case (PADDR)
				`AFC_OFF_CSR: ctrl_nxt = PWDATA[11:0] & `AFC_CSR_WMASK;
				`AFC_OFF_CNT: cnt_nxt = PWDATA[AW-1:0];
				`AFC_OFF_TAPB: tb_nxt = PWDATA[AW-1:0];
				`AFC_OFF_COEFB: cb_nxt = PWDATA[AW-1:0];
				`AFC_OFF_STEP: step_nxt = PWDATA[DW-1:0];
				`AFC_OFF_IRQ_ST: irq_st_nxt = irq_st_r & ~PWDATA[1:0];
				`AFC_OFF_IRQ_MASK: irq_mask_nxt = PWDATA[1:0];
				default: pend_data_nxt = pend_data_r;
			endcase
		end
		// A sample arriving while the engine is busy waits here
		if (sample_wr)
		begin
			pend_nxt = 1'b1;
			pend_data_nxt = PWDATA[DW-1:0];
		end
		if (rd_ok && PADDR == `AFC_OFF_RESULT)
			full_nxt = 1'b0;
		if (ev_full)
			full_nxt = 1'b1;
		if (ev_full && ctrl_r[`AFC_CSR_IE])
			irq_st_nxt[`AFC_IRQ_FULL] = 1'b1;
		if (ev_upd)
			irq_st_nxt[`AFC_IRQ_UPD] = 1'b1;
		irq_nxt = |(irq_st_r & irq_mask_r);
		pready_nxt = acc_ph & ~pready_r;
		prdata_nxt = 32'h0000_0000;
		pslverr_nxt = 1'b0;
		if (pready_nxt)
		begin
			prdata_nxt = PWRITE ? 32'h0000_0000 : rd_data;
			pslverr_nxt = rd_err;
		end
	end

	always_ff @(posedge REF_CLK or posedge RST)
	begin
		if (RST)
		begin
			ctrl_r <= `AFC_CSR_RST;
			cnt_r <= '0;
			tb_r <= '0;
			cb_r <= '0;
			step_r <= '0;
			pend_r <= 1'b0;
			pend_data_r <= '0;
			irq_st_r <= `AFC_IRQ_RST;
			irq_mask_r <= `AFC_IRQ_RST;
			full_r <= 1'b0;
			irq_r <= 1'b0;
			pready_r <= 1'b0;
			prdata_r <= 32'h0000_0000;
			pslverr_r <= 1'b0;
		end
		else
		begin
			ctrl_r <= ctrl_nxt;
			cnt_r <= cnt_nxt;
			tb_r <= tb_nxt;
			cb_r <= cb_nxt;
			step_r <= step_nxt;
			pend_r <= pend_nxt;
			pend_data_r <= pend_data_nxt;
			irq_st_r <= irq_st_nxt;
			irq_mask_r <= irq_mask_nxt;
			full_r <= full_nxt;
			irq_r <= irq_nxt;
			pready_r <= pready_nxt;
			prdata_r <= prdata_nxt;
			pslverr_r <= pslverr_nxt;
		end
	end

	assign PRDATA = prdata_r;
	assign PREADY = pready_r;
	assign PSLVERR = pslverr_r;
	assign IRQ = irq_r;

	// ************************************************************
	// Filter engine
	// ************************************************************
	assign ptr_inc = (ptr_r >= cnt_r) ? '0 : AW'(ptr_r + 1'b1);
	assign tap_off = (ptr_r >= idx_r) ? AW'(ptr_r - idx_r) : AW'(ptr_r + cnt_r + 1'b1 - idx_r);
	assign tap_ra = AW'(tb_r + tap_off);
	assign coef_ra = AW'(cb_r + idx_r);
	assign tap_rd = tap_mem[tap_ra];
	assign coef_rd = coef_mem[coef_ra];
	assign mac_a = (state_r == afc_pkg::ST_UPD) ? step_r : coef_rd;

	afc_mac #(
		.DW(DW)
	) u_mac (
		.a(mac_a),
		.b(tap_rd),
		.p(mac_p)
	);

	always_comb
	begin
		state_nxt = state_r;
		idx_nxt = idx_r;
		acc_nxt = acc_r;
		ptr_nxt = ptr_r;
		prime_nxt = prime_r;
		result_nxt = result_r;
		take = 1'b0;
		ev_full = 1'b0;
		ev_upd = 1'b0;
		sum = acc_r + ACCW'(mac_p);
		upd_val = sat(ACCW'(coef_rd) + ACCW'(mac_p));
		case (state_r)
			afc_pkg::ST_IDLE:
			begin
				if (pend_r && en && !apb_tap_we)
				begin
					take = 1'b1;
					ptr_nxt = ptr_inc;
					if (prime_r >= cnt_r)
					begin
						state_nxt = afc_pkg::ST_FILT;
						idx_nxt = '0;
						acc_nxt = '0;
					end
					else
						prime_nxt = AW'(prime_r + 1'b1);
				end
			end
			afc_pkg::ST_FILT:
			begin
				if (idx_r == cnt_r)
				begin
					result_nxt = sat(sum);
					ev_full = 1'b1;
					idx_nxt = '0;
					state_nxt = adaptive_mode ? afc_pkg::ST_WAITK : afc_pkg::ST_IDLE;
				end
				else
				begin
					acc_nxt = sum;
					idx_nxt = AW'(idx_r + 1'b1);
				end
			end
			afc_pkg::ST_WAITK:
			begin
				if (step_wr)
					state_nxt = afc_pkg::ST_UPD;
			end
			afc_pkg::ST_UPD:
			begin
				idx_nxt = AW'(idx_r + 1'b1);
				if (idx_r == cnt_r)
				begin
					ev_upd = 1'b1;
					idx_nxt = '0;
					state_nxt = afc_pkg::ST_IDLE;
				end
			end
			default: state_nxt = afc_pkg::ST_IDLE;
		endcase
		if (!en)
		begin
			state_nxt = afc_pkg::ST_IDLE;
			prime_nxt = '0;
		end
	end

	always_ff @(posedge REF_CLK or posedge RST)
	begin
		if (RST)
		begin
			state_r <= afc_pkg::ST_IDLE;
			idx_r <= '0;
			acc_r <= '0;
			ptr_r <= '0;
			prime_r <= '0;
			result_r <= '0;
		end
		else
		begin
			state_r <= state_nxt;
			idx_r <= idx_nxt;
			acc_r <= acc_nxt;
			ptr_r <= ptr_nxt;
			prime_r <= prime_nxt;
			result_r <= result_nxt;
		end
	end

	// ************************************************************
	// Shared tap and coefficient memories
	// ************************************************************
	always_comb
	begin
		tap_we = take | apb_tap_we;
		tap_wa = take ? AW'(tb_r + ptr_inc) : mem_idx;
		tap_wd = take ? pend_data_r : PWDATA[DW-1:0];
		coef_we = (state_r == afc_pkg::ST_UPD) | apb_coef_we;
		coef_wa = (state_r == afc_pkg::ST_UPD) ? coef_ra : mem_idx;
		coef_wd = (state_r == afc_pkg::ST_UPD) ? upd_val : PWDATA[DW-1:0];
	end

	always_ff @(posedge REF_CLK)
	begin
		if (tap_we)
			tap_mem[tap_wa] <= tap_wd;
		if (coef_we)
			coef_mem[coef_wa] <= coef_wd;
	end

	// ************************************************************
	// Assertions
	// ************************************************************
	default clocking cb_main @(posedge REF_CLK);
	endclocking
	default disable iff (RST);

	property p_filt_result;
		(state_r == afc_pkg::ST_FILT && idx_r == cnt_r && en) |=> full_r;
	endproperty
	a_filt_result: assert property (p_filt_result) else $error("result flag not set");

	property p_upd_write;
		(state_r == afc_pkg::ST_UPD) |-> coef_we && coef_wa == AW'(cb_r + idx_r);
	endproperty
	a_upd_write: assert property (p_upd_write) else $error("update writes wrong coefficient");

	property p_adp_wait;
		(state_r == afc_pkg::ST_FILT && idx_r == cnt_r && adaptive_mode && en) |=> state_r == afc_pkg::ST_WAITK;
	endproperty
	a_adp_wait: assert property (p_adp_wait) else $error("no stall after filter");

	property p_wait_hold;
		(state_r == afc_pkg::ST_WAITK && !step_wr && en) |=> state_r == afc_pkg::ST_WAITK;
	endproperty
	a_wait_hold: assert property (p_wait_hold) else $error("left wait without step");

	property p_irq_full;
		(ev_full && ctrl_r[`AFC_CSR_IE]) |=> irq_st_r[`AFC_IRQ_FULL] ##1 (IRQ || !irq_mask_r[0]);
	endproperty
	a_irq_full: assert property (p_irq_full) else $error("full interrupt missing");

	property p_irq_off;
		(ev_full && !ctrl_r[`AFC_CSR_IE] && !irq_st_r[0]) |=> !irq_st_r[`AFC_IRQ_FULL];
	endproperty
	a_irq_off: assert property (p_irq_off) else $error("disabled interrupt raised");

	property p_busy_end;
		(state_r == afc_pkg::ST_UPD && idx_r == cnt_r) |-> busy ##1 !busy;
	endproperty
	a_busy_end: assert property (p_busy_end) else $error("busy bit wrong at update end");

	property p_zero_step;
		(state_r == afc_pkg::ST_UPD && step_r == '0) |-> coef_wd == coef_rd;
	endproperty
	a_zero_step: assert property (p_zero_step) else $error("zero step changed coefficient");

	property p_ptr_adv;
		(take && ptr_r < cnt_r) |=> ptr_r == AW'($past(ptr_r) + 1'b1);
	endproperty
	a_ptr_adv: assert property (p_ptr_adv) else $error("delay line pointer did not advance");

	c_filter_done: cover property (ev_full);
	c_update_done: cover property (ev_upd);
	c_irq_high: cover property ($rose(IRQ));
	c_pending_sample: cover property (sample_wr && busy);
	c_plain_fir: cover property (state_r == afc_pkg::ST_FILT && idx_r == cnt_r && !adaptive_mode);
endmodule // afc_top

// ### include/afc_regs.svh
`ifndef AFC_REGS_SVH
`define AFC_REGS_SVH
// Overview of operation
// - Filter session output is sum of coefficient i times sample delayed by i.
// - Update session adds step times sample delayed by i to coefficient i.
// - Tap buffer and coefficient buffer each occupy a 4K-word shared memory.
// - Control value 0x805 selects adaptive real FIR, full interrupt, enable.
// - Adaptive mode filters one sample, waits for a step, then updates.
// - Placing a result raises an output-full interrupt request when enabled.
// - Output-full interrupt enable is control status bit 11, read/write.
// - Control status bit 3 reads set while waiting for a step and while an update is in progress.

`define AFC_OFF_CSR 16'h0000
`define AFC_OFF_CNT 16'h0004
`define AFC_OFF_TAPB 16'h0008
`define AFC_OFF_COEFB 16'h000c
`define AFC_OFF_SAMPLE 16'h0010
`define AFC_OFF_RESULT 16'h0014
`define AFC_OFF_STEP 16'h0018
`define AFC_OFF_IRQ_ST 16'h001c
`define AFC_OFF_IRQ_MASK 16'h0020
`define AFC_WIN_REGS 2'h0
`define AFC_WIN_TAP 2'h1
`define AFC_WIN_COEF 2'h2
`define AFC_CSR_EN 0
`define AFC_CSR_ADP 2
`define AFC_CSR_BUSY 3
`define AFC_CSR_FULL 7
`define AFC_CSR_IE 11
`define AFC_CSR_WMASK 12'h805
`define AFC_CSR_RST 12'h000
`define AFC_IRQ_FULL 0
`define AFC_IRQ_UPD 1
`define AFC_IRQ_RST 2'h0
`endif

// ### include/afc_pkg.sv
package afc_pkg;
	typedef enum logic [1:0] {
		ST_IDLE = 2'b00,
		ST_FILT = 2'b01,
		ST_WAITK = 2'b10,
		ST_UPD = 2'b11
	} afc_state_t;
endpackage

// ### rtl/afc_mac.sv
`timescale 1ns/100ps
module afc_mac #(
	parameter int DW = 16
) (
	input wire logic signed [DW-1:0] a,
	input wire logic signed [DW-1:0] b,
	output logic signed [DW:0] p
);
	logic signed [2*DW-1:0] prod;

	// Fractional product, scaled back to the operand format plus one guard bit
	assign prod = a * b;
	assign p = prod[2*DW-1:DW-1];
endmodule // afc_mac

// ### tb/afc_host.sv
`timescale 1ns/100ps
module afc_host (
	input wire logic clk,
	input wire logic [31:0] prdata,
	input wire logic pready,
	input wire logic pslverr,
	output logic psel,
	output logic penable,
	output logic pwrite,
	output logic [15:0] paddr,
	output logic [31:0] pwdata
);
	logic timed_out = 1'b0;
	initial
	begin
		psel = 1'b0;
		penable = 1'b0;
		pwrite = 1'b0;
		paddr = 16'h0000;
		pwdata = 32'h0000_0000;
	end
	// ***********************************
	// One APB transfer, held until pready
	// ***********************************
	task automatic xfer(input logic w, input logic [15:0] a, input logic [31:0] v,
		output logic [31:0] rd, output logic er);
		int n;
		n = 0;
		@(posedge clk);
		psel <= 1'b1;
		penable <= 1'b0;
		pwrite <= w;
		paddr <= a;
		pwdata <= v;
		@(posedge clk);
		penable <= 1'b1;
		do
		begin
			@(posedge clk);
			n++;
		end
		while (pready !== 1'b1 && n < 20);
		timed_out = (pready !== 1'b1);
		rd = prdata;
		er = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
		// Released data bus shows no stale value
		pwdata <= ~v;
	endtask
endmodule // afc_host

// ### tb/adaptive_fir_filter_coprocessor_tb.sv
`timescale 1ns/100ps
`include "afc_regs.svh"
module adaptive_fir_filter_coprocessor_tb;
	logic ref_clk = 1'b0;
	logic rst = 1'b1;
	logic psel, penable, pwrite, pready, pslverr, irq, er;
	logic [15:0] paddr;
	logic [31:0] pwdata, prdata, d;
	int error_cnt = 0;
	int tests_run = 0;
	always #2 ref_clk = ~ref_clk;
	afc_top #(.DW(16), .AW(12)) afc_top_i (.REF_CLK(ref_clk), .RST(rst), .PSEL(psel),
		.PENABLE(penable), .PWRITE(pwrite), .PADDR(paddr), .PWDATA(pwdata), .PRDATA(prdata),
		.PREADY(pready), .PSLVERR(pslverr), .IRQ(irq));
	afc_host afc_host_i (.clk(ref_clk), .prdata(prdata), .pready(pready), .pslverr(pslverr),
		.psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata));
	// *******
	// Helpers
	// *******
	task automatic print_verdict;
		if (error_cnt == 0 && tests_run > 0)
			$display("== PASSED ==");
		else
			$display("== FAILED ==");
		$finish;
	endtask
	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		tests_run++;
		if (got !== exp)
		begin
			error_cnt++;
			$display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask
	task automatic bound(input logic hung);
		if (hung)
		begin
			error_cnt++;
			print_verdict();
		end
	endtask
	task automatic bus(input logic w, input logic [15:0] a, input logic [31:0] v);
		afc_host_i.xfer(w, a, v, d, er);
		bound(afc_host_i.timed_out);
	endtask
	task automatic wr(input logic [15:0] a, input logic [31:0] v);
		bus(1'b1, a, v);
	endtask
	task automatic rdc(input logic [15:0] a, input logic [31:0] e);
		bus(1'b0, a, 32'h0000_0000);
		chk(d, e);
	endtask
	task automatic wait_irq;
		int n;
		n = 0;
		while (irq !== 1'b1 && n < 200)
		begin
			@(posedge ref_clk);
			n++;
		end
		bound(irq !== 1'b1);
	endtask
	task automatic wait_idle;
		int n;
		n = 0;
		do
		begin
			bus(1'b0, `AFC_OFF_CSR, 32'h0000_0000);
			n++;
		end
		while (d[3] !== 1'b0 && n < 50);
		bound(d[3] !== 1'b0);
	endtask
	task automatic irq_is(input logic e);
		repeat (2) @(posedge ref_clk);
		chk({31'h0, irq}, {31'h0, e});
	endtask
	// ********
	// Sequence
	// ********
	initial
	begin
		repeat (6) @(posedge ref_clk);
		rst <= 1'b0;
		rdc(`AFC_OFF_CSR, 32'h0000_0000);
		wr(16'h8000, 32'h0000_0000);
		wr(16'h8004, 32'h0000_0000);
		wr(`AFC_OFF_TAPB, 32'h0000_0000);
		wr(`AFC_OFF_COEFB, 32'h0000_0000);
		wr(`AFC_OFF_CNT, 32'h0000_0001);
		wr(`AFC_OFF_IRQ_MASK, 32'h0000_0003);
		wr(`AFC_OFF_CSR, 32'h0000_0805);
		rdc(`AFC_OFF_CSR, 32'h0000_0805);
		wr(`AFC_OFF_SAMPLE, 32'h0000_4000);
		rdc(`AFC_OFF_IRQ_ST, 32'h0000_0000);
		wr(`AFC_OFF_SAMPLE, 32'h0000_2000);
		wait_irq();
		rdc(`AFC_OFF_CSR, 32'h0000_088d);
		rdc(`AFC_OFF_RESULT, 32'h0000_0000);
		rdc(`AFC_OFF_IRQ_ST, 32'h0000_0001);
		wr(`AFC_OFF_IRQ_ST, 32'h0000_0001);
		wr(`AFC_OFF_STEP, 32'h0000_4000);
		wait_idle();
		rdc(`AFC_OFF_IRQ_ST, 32'h0000_0002);
		rdc(16'h8000, 32'h0000_1000);
		rdc(16'h8004, 32'h0000_2000);
		wr(`AFC_OFF_IRQ_MASK, 32'h0000_0001);
		irq_is(1'b0);
		wr(`AFC_OFF_IRQ_MASK, 32'h0000_0002);
		irq_is(1'b1);
		wr(`AFC_OFF_IRQ_ST, 32'h0000_0002);
		irq_is(1'b0);
		wr(`AFC_OFF_IRQ_MASK, 32'h0000_0003);
		wr(`AFC_OFF_SAMPLE, 32'h0000_6000);
		wait_irq();
		rdc(`AFC_OFF_RESULT, 32'h0000_1400);
		bus(1'b0, 16'h4000, 32'h0000_0000);
		chk({31'h0, er}, 32'h0000_0001);
		wr(`AFC_OFF_STEP, 32'h0000_0000);
		wait_idle();
		rdc(16'h8000, 32'h0000_1000);
		rdc(16'h8004, 32'h0000_2000);
		bus(1'b0, 16'h0024, 32'h0000_0000);
		chk({31'h0, er}, 32'h0000_0001);
		wr(`AFC_OFF_CSR, 32'h0000_0005);
		wr(`AFC_OFF_IRQ_ST, 32'h0000_0003);
		wr(`AFC_OFF_SAMPLE, 32'h0000_1000);
		repeat (20) @(posedge ref_clk);
		rdc(`AFC_OFF_IRQ_ST, 32'h0000_0000);
		wr(`AFC_OFF_CSR, 32'h0000_0000);
		rdc(`AFC_OFF_CSR, 32'h0000_0080);
		wr(`AFC_OFF_CSR, 32'h0000_0801);
		wr(`AFC_OFF_SAMPLE, 32'h0000_0800);
		rdc(`AFC_OFF_IRQ_ST, 32'h0000_0000);
		wr(`AFC_OFF_SAMPLE, 32'h0000_4000);
		wait_irq();
		rdc(`AFC_OFF_CSR, 32'h0000_0881);
		rdc(`AFC_OFF_RESULT, 32'h0000_0a00);
		rdc(`AFC_OFF_IRQ_ST, 32'h0000_0001);
		print_verdict();
	end
endmodule // adaptive_fir_filter_coprocessor_tb
